// ===== src/eit_map.svh
// Constants of the two-wire target front end: field positions, function codes, reset values
`ifndef EIT_MAP_SVH
`define EIT_MAP_SVH

// Device address byte fields
`define EIT_DA_TYPE_MSB 7
`define EIT_DA_TYPE_LSB 4
`define EIT_DA_STRAP_HI 3
`define EIT_DA_STRAP_LO 2
`define EIT_DA_TOP_BIT 1
`define EIT_DA_RW_BIT 0

// Word address byte fields
`define EIT_WA_FN_MSB 7
`define EIT_WA_FN_LSB 6
`define EIT_WA_IDX_MSB 3

// Function select codes for the identification identifier
`define EIT_FN_PAGE 2'h0
`define EIT_FN_FREEZE 2'h1
`define EIT_FN_UID 2'h2
`define EIT_FN_LOCKBIT 2'h3

// Data byte fields of the freeze and lock-bit commands
`define EIT_FREEZE_DATA_BIT 1
`define EIT_LOCKBIT_DATA_BIT 0

// Bit counter: last data bit index and acknowledge slot index
`define EIT_LAST_DATA_BIT 4'h7
`define EIT_ACK_SLOT 4'h8
// Bit count seen at a Stop that follows an acknowledge: the clock rise under the Stop
`define EIT_STOP_SLOT 4'h1

// Reset values
`define EIT_ADDR_RST 9'h000
`define EIT_FN_RST 2'h0

`endif

// ===== src/eit_pkg.sv
// Types shared by the two-wire target front end
`include "eit_map.svh"

package eit_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WORD,
		ST_WDATA,
		ST_RDATA
	} eit_state_t;

	// System-domain state
	typedef struct packed {
		logic [1:0] scl_sy;
		logic scl_q;
		logic [1:0] sda_sy;
		logic sda_q;
		logic [1:0] tgl_sy;
		logic tgl_q;
		logic [1:0] wp_sy;
		logic [1:0] slo_sy;
		logic [1:0] shi_sy;
		eit_state_t st;
		logic [3:0] bit_cnt;
		logic rw;
		logic ident;
		logic nack;
		logic wr_seen;
		logic [1:0] func;
		logic [8:0] addr;
		logic [7:0] tx;
		logic drv;
		logic [7:0] wr_data;
		logic wr_valid;
		logic rd_req;
		logic freeze_req;
		logic sl_wr;
		logic sl_val;
		logic prog_start;
	} eit_sys_t;

	// Link-domain receive state
	typedef struct packed {
		logic [7:0] shreg;
		logic tgl;
	} eit_lnk_t;

endpackage

// ===== src/eit_link.sv
// Link-clock end of the two-wire target: bit sampling and open-drain drive timing
`timescale 1ns/1ns
`default_nettype none

module eit_link (
	input wire logic scl_clk_i,
	input wire logic rst_b_i,
	input wire logic sda_i,
	input wire logic drive_low_i,
	output logic [7:0] rx_byte_o,
	output logic bit_tgl_o,
	output logic sda_oe_o
);

	eit_pkg::eit_lnk_t r_ff;
	eit_pkg::eit_lnk_t nxt_r;
	logic oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Sampling on the rising clock edge, MSB arrives first
	always_comb begin
		nxt_r = r_ff;
		nxt_r.shreg = {r_ff.shreg[6:0], sda_i};
		nxt_r.tgl = ~r_ff.tgl;
	end

	always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drive changes only on the falling edge; the request is set by the system
	// side long before that edge and held, so it is quasi-static here
	always_ff @(negedge scl_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oe_ff <= 1'h0;
		end else begin
			oe_ff <= drive_low_i;
		end
	end

	// The shift register only moves on a rising edge, and the system side reads it
	// after seeing the toggle, so the word is stable when taken
	assign rx_byte_o = r_ff.shreg;
	assign bit_tgl_o = r_ff.tgl;
	assign sda_oe_o = oe_ff;

endmodule // eit_link

`default_nettype wire

// ===== src/eit_target.sv
// Two-wire target front end: framing, address decode, protection gating, standby
// What this block does
// - Sample data on clock rise; change own data drive only after clock fall.
// - Every byte travels most significant bit first, one bit per clock.
// - Nine clocks per byte: eight data, ninth carries acknowledge from receiver.
// - Data falling with clock high is Start; ignore everything until one.
// - Data rising with clock high is Stop; ends the transaction.
// - Stop closing a write launches programming; any other Stop gives standby.
// - Acknowledge: master releases data, device holds it low through ninth high.
// - Standby after power-up, after read Stop, after internal operation ends.
// - Write-protect input high blocks array and identification page writes.
// - Soft lock bit at one blocks array and identification page writes.
// - First byte: type identifier bits 7-4, three address bits, read/write bit.
// - Two identifiers: main array, or identification page/freeze/lock bit/unique ID.
// - Address bits 3 and 2 must equal the two strap inputs.
// - Address bit 0: one reads, zero writes.
// - Acknowledge address on match, else no acknowledge and back to standby.
// - Array access: address bit 1 is top array bit; otherwise ignored.
// - Freeze accepted only as write; unique ID only as read.
// - After a write address acknowledge, receive one word address byte; acknowledge it unless it selects unique ID.
// - Word bits 7:6 pick function; bits 3:0 index page and unique ID bytes.
// - Write-protect high: acknowledge addresses, refuse array and identification page write data bytes.
`timescale 1ns/1ns
`default_nettype none
`include "eit_map.svh"

module eit_target #(
	// Type identifier values; the values are arbitrary
	parameter logic [3:0] TYPE_ARRAY_ID = 4'h5,
	parameter logic [3:0] TYPE_IDENT_ID = 4'h6
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic scl_clk_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic wp_i,
	input wire logic strap_select_low_i,
	input wire logic strap_select_high_i,
	input wire logic soft_write_lock_bit_i,
	input wire logic ident_page_freeze_i,
	input wire logic prog_busy_i,
	input wire logic [7:0] rd_data_i,
	output logic standby_o,
	output logic ident_sel_o,
	output logic [1:0] function_select_field_o,
	output logic [8:0] mem_addr_o,
	output logic [7:0] wr_data_o,
	output logic wr_valid_o,
	output logic rd_req_o,
	output logic freeze_req_o,
	output logic soft_lock_wr_o,
	output logic soft_lock_val_o,
	output logic prog_start_o
);

	eit_pkg::eit_sys_t s_ff;
	eit_pkg::eit_sys_t nxt_s;

	logic [7:0] rx_byte;
	logic bit_tgl;

	////////////////////////////////////////////////////////////////////////////////
	// Link-clock end
	eit_link u_link (
		.scl_clk_i(scl_clk_i),
		.rst_b_i(rst_b_i),
		.sda_i(sda_i),
		.drive_low_i(s_ff.drv),
		.rx_byte_o(rx_byte),
		.bit_tgl_o(bit_tgl),
		.sda_oe_o(sda_oe_o)
	);

	// Open drain: the line is only ever pulled low or released
	assign sda_o = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic start_v;
		logic stop_v;
		logic rise_v;
		logic ok_v;
		logic prot_v;
		logic strap_v;
		logic is_arr_v;
		logic is_id_v;
		logic [7:0] byte_v;

		start_v = 1'h0;
		stop_v = 1'h0;
		rise_v = 1'h0;
		ok_v = 1'h0;
		prot_v = 1'h0;
		strap_v = 1'h0;
		is_arr_v = 1'h0;
		is_id_v = 1'h0;
		byte_v = rx_byte;

		nxt_s = s_ff;

		// Synchronisers: only the second stage and beyond are looked at
		nxt_s.scl_sy = {s_ff.scl_sy[0], scl_clk_i};
		nxt_s.scl_q = s_ff.scl_sy[1];
		nxt_s.sda_sy = {s_ff.sda_sy[0], sda_i};
		nxt_s.sda_q = s_ff.sda_sy[1];
		nxt_s.tgl_sy = {s_ff.tgl_sy[0], bit_tgl};
		nxt_s.tgl_q = s_ff.tgl_sy[1];
		nxt_s.wp_sy = {s_ff.wp_sy[0], wp_i};
		nxt_s.slo_sy = {s_ff.slo_sy[0], strap_select_low_i};
		nxt_s.shi_sy = {s_ff.shi_sy[0], strap_select_high_i};

		// One-cycle strobes
		nxt_s.wr_valid = 1'h0;
		nxt_s.rd_req = 1'h0;
		nxt_s.freeze_req = 1'h0;
		nxt_s.sl_wr = 1'h0;
		nxt_s.prog_start = 1'h0;

		// Address advance after each data byte; a page write wraps inside its page
		if (s_ff.wr_valid) begin
			nxt_s.addr[3:0] = s_ff.addr[3:0] + 4'h1;
		end
		if (s_ff.rd_req) begin
			if (s_ff.ident) begin
				nxt_s.addr[3:0] = s_ff.addr[3:0] + 4'h1;
			end else begin
				nxt_s.addr = s_ff.addr + 9'h001;
			end
		end

		// Conditions seen on the synchronised pins, clock high in both samples
		start_v = s_ff.scl_sy[1] & s_ff.scl_q & s_ff.sda_q & ~s_ff.sda_sy[1];
		stop_v = s_ff.scl_sy[1] & s_ff.scl_q & ~s_ff.sda_q & s_ff.sda_sy[1];
		rise_v = s_ff.tgl_sy[1] ^ s_ff.tgl_q;
		prot_v = s_ff.wp_sy[1] | soft_write_lock_bit_i;

		if (start_v) begin
			// Abandon whatever was going on, even mid-byte
			nxt_s.st = eit_pkg::ST_DEV;
			nxt_s.bit_cnt = 4'h0;
			nxt_s.drv = 1'h0;
			nxt_s.nack = 1'h0;
			nxt_s.wr_seen = 1'h0;
		end else if (stop_v) begin
			// Only a Stop right after a data acknowledge commits the write; the clock
			// rise under the Stop has already been counted, so exactly one bit is seen
			if (s_ff.st == eit_pkg::ST_WDATA && s_ff.wr_seen && s_ff.bit_cnt == `EIT_STOP_SLOT) begin
				nxt_s.prog_start = 1'h1;
			end
			nxt_s.st = eit_pkg::ST_IDLE;
			nxt_s.bit_cnt = 4'h0;
			nxt_s.drv = 1'h0;
			nxt_s.wr_seen = 1'h0;
		end else if (rise_v && s_ff.st != eit_pkg::ST_IDLE) begin
			if (s_ff.bit_cnt == `EIT_ACK_SLOT) begin
				// Ninth clock done: release, then go on or drop out
				nxt_s.bit_cnt = 4'h0;
				nxt_s.drv = 1'h0;
				if (s_ff.nack) begin
					nxt_s.st = eit_pkg::ST_IDLE;
					nxt_s.nack = 1'h0;
				end else if (s_ff.st == eit_pkg::ST_RDATA) begin
					// Bit 0 holds the acknowledge slot level; after the address slot it
					// is our own low, afterwards it is the master's answer
					if (!byte_v[0]) begin
						nxt_s.tx = {rd_data_i[6:0], 1'h0};
						nxt_s.drv = ~rd_data_i[7];
						nxt_s.rd_req = 1'h1;
					end else begin
						nxt_s.st = eit_pkg::ST_IDLE;
					end
				end
			end else begin
				nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
				if (s_ff.st == eit_pkg::ST_RDATA) begin
					// Transmit: next bit on the coming fall, release for master answer
					if (s_ff.bit_cnt == `EIT_LAST_DATA_BIT) begin
						nxt_s.drv = 1'h0;
					end else begin
						nxt_s.drv = ~s_ff.tx[7];
						nxt_s.tx = {s_ff.tx[6:0], 1'h0};
					end
				end else if (s_ff.bit_cnt == `EIT_LAST_DATA_BIT) begin
					// Eighth bit received: decide the acknowledge
					unique case (s_ff.st)
						eit_pkg::ST_DEV: begin
							is_arr_v = byte_v[`EIT_DA_TYPE_MSB:`EIT_DA_TYPE_LSB] == TYPE_ARRAY_ID;
							is_id_v = byte_v[`EIT_DA_TYPE_MSB:`EIT_DA_TYPE_LSB] == TYPE_IDENT_ID;
							strap_v = byte_v[`EIT_DA_STRAP_HI] == s_ff.shi_sy[1]
								&& byte_v[`EIT_DA_STRAP_LO] == s_ff.slo_sy[1];
							// Busy programming: stay silent so the master can poll
							ok_v = (is_arr_v | is_id_v) & strap_v & ~prog_busy_i;
							// A read of the freeze function is refused
							if (is_id_v && byte_v[`EIT_DA_RW_BIT] && s_ff.func == `EIT_FN_FREEZE) begin
								ok_v = 1'h0;
							end
							nxt_s.nack = ~ok_v;
							nxt_s.drv = ok_v;
							if (ok_v) begin
								nxt_s.rw = byte_v[`EIT_DA_RW_BIT];
								nxt_s.ident = is_id_v;
								if (is_arr_v) begin
									nxt_s.addr[8] = byte_v[`EIT_DA_TOP_BIT];
								end
								nxt_s.st = byte_v[`EIT_DA_RW_BIT] ? eit_pkg::ST_RDATA : eit_pkg::ST_WORD;
							end
						end
						eit_pkg::ST_WORD: begin
							ok_v = 1'h1;
							if (s_ff.ident) begin
								nxt_s.func = byte_v[`EIT_WA_FN_MSB:`EIT_WA_FN_LSB];
								nxt_s.addr = {5'h00, byte_v[`EIT_WA_IDX_MSB:0]};
								// Unique ID only as a read
								ok_v = byte_v[`EIT_WA_FN_MSB:`EIT_WA_FN_LSB] != `EIT_FN_UID;
							end else begin
								nxt_s.addr = {s_ff.addr[8], byte_v};
							end
							nxt_s.nack = ~ok_v;
							nxt_s.drv = ok_v;
							nxt_s.st = eit_pkg::ST_WDATA;
						end
						eit_pkg::ST_WDATA: begin
							nxt_s.wr_data = byte_v;
							if (!s_ff.ident) begin
								ok_v = ~prot_v;
								nxt_s.wr_valid = ok_v;
							end else begin
								unique case (s_ff.func)
									`EIT_FN_PAGE: begin
										ok_v = ~prot_v & ~ident_page_freeze_i;
										nxt_s.wr_valid = ok_v;
									end
									`EIT_FN_FREEZE: begin
										// Freezing twice, or without the key bit, is refused
										ok_v = byte_v[`EIT_FREEZE_DATA_BIT] & ~ident_page_freeze_i;
										nxt_s.freeze_req = ok_v;
									end
									`EIT_FN_LOCKBIT: begin
										ok_v = 1'h1;
										nxt_s.sl_wr = 1'h1;
										nxt_s.sl_val = byte_v[`EIT_LOCKBIT_DATA_BIT];
									end
									`EIT_FN_UID: begin
										ok_v = 1'h0;
									end
								endcase
							end
							// Refused data ends the transfer; a later Stop then only idles
							nxt_s.nack = ~ok_v;
							nxt_s.drv = ok_v;
							nxt_s.wr_seen = s_ff.wr_seen | ok_v;
						end
						default: begin
							nxt_s.drv = 1'h0;
						end
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; reset keeps the line released and the block in standby
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign standby_o = (s_ff.st == eit_pkg::ST_IDLE) & ~prog_busy_i;
	assign ident_sel_o = s_ff.ident;
	assign function_select_field_o = s_ff.func;
	assign mem_addr_o = s_ff.addr;
	assign wr_data_o = s_ff.wr_data;
	assign wr_valid_o = s_ff.wr_valid;
	assign rd_req_o = s_ff.rd_req;
	assign freeze_req_o = s_ff.freeze_req;
	assign soft_lock_wr_o = s_ff.sl_wr;
	assign soft_lock_val_o = s_ff.sl_val;
	assign prog_start_o = s_ff.prog_start;

endmodule // eit_target

`default_nettype wire

// ===== tb/eit_target_assertions.sv
// Port-level assertions for the two-wire target front end
`timescale 1ns/1ns
`default_nettype none

module eit_chk (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic scl_clk_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic wp_i,
	input wire logic soft_write_lock_bit_i,
	input wire logic prog_busy_i,
	input wire logic standby_o,
	input wire logic wr_valid_o,
	input wire logic rd_req_o,
	input wire logic prog_start_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////
	sequence s_pulse(x);
		x ##1 !x;
	endsequence
	property p_sda_low; sda_o == 1'h0; endproperty
	a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
	property p_oe_fall; $changed(sda_oe_o) |-> !scl_clk_i; endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("drive changed with clock high");
	property p_ack_hold; scl_clk_i && sda_oe_o |=> sda_oe_o || !scl_clk_i; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("drive dropped in high phase");
	property p_wv_lock; wr_valid_o |-> !soft_write_lock_bit_i; endproperty
	a_wv_lock: assert property (p_wv_lock) else $error("write under soft lock");
	property p_wv_wp; wr_valid_o |-> !wp_i && !$past(wp_i, 4); endproperty
	a_wv_wp: assert property (p_wv_wp) else $error("write under protect pin");
	property p_busy_sb; prog_busy_i |-> !standby_o; endproperty
	a_busy_sb: assert property (p_busy_sb) else $error("standby while busy");
	property p_busy_ack; $rose(sda_oe_o) |-> !prog_busy_i; endproperty
	a_busy_ack: assert property (p_busy_ack) else $error("answer while busy");
	property p_sb_oe; standby_o |-> !sda_oe_o; endproperty
	a_sb_oe: assert property (p_sb_oe) else $error("drive in standby");
	property p_prog; prog_start_o |-> s_pulse(prog_start_o); endproperty
	a_prog: assert property (p_prog) else $error("program start not a pulse");
	property p_rdreq; rd_req_o |-> s_pulse(rd_req_o); endproperty
	a_rdreq: assert property (p_rdreq) else $error("read request not a pulse");
endmodule // eit_chk

bind eit_target eit_chk eit_chk_inst (
	.clk_sys_i,
	.rst_b_i,
	.scl_clk_i,
	.sda_o,
	.sda_oe_o,
	.wp_i,
	.soft_write_lock_bit_i,
	.prog_busy_i,
	.standby_o,
	.wr_valid_o,
	.rd_req_o,
	.prog_start_o
);
`default_nettype wire

// ===== tb/eit_master.sv
// Bus master model: makes the serial clock and pulls the data line low
`timescale 1ns/1ns
`default_nettype none

module eit_master (
	input wire logic tick_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial begin
		scl_o = 1'h1;
		sda_low_o = 1'h0;
	end
	////////////////////////////////////////
	// Six ticks a phase keeps both clock phases above 260 ns
	task automatic wt();
		repeat (6) @(posedge tick_i);
	endtask
	// One tick after the fall before data moves, so no edge looks like a Start
	task automatic bit_io(input logic b, output logic s);
		@(posedge tick_i);
		sda_low_o = !b;
		wt();
		scl_o = 1'h1;
		wt();
		s = sda_i;
		scl_o = 1'h0;
	endtask
	task automatic byte_io(input logic [7:0] b, input logic a_in, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(a_in, s);
		ack = !s;
	endtask
	task automatic start();
		@(posedge tick_i);
		sda_low_o = 1'h0;
		wt();
		scl_o = 1'h1;
		wt();
		sda_low_o = 1'h1;
		wt();
		scl_o = 1'h0;
	endtask
	// Clock stays high afterwards: it stands still outside frames
	task automatic stop();
		@(posedge tick_i);
		sda_low_o = 1'h1;
		wt();
		scl_o = 1'h1;
		wt();
		sda_low_o = 1'h0;
		wt();
	endtask
endmodule // eit_master
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the two-wire target front end
`timescale 1ns/1ns
`default_nettype none

module testbench;
	// Type identifiers; the values are arbitrary
	localparam logic [3:0] T_ARR = 4'h5;
	localparam logic [3:0] T_ID = 4'h6;
	logic clk_sys_i = 1'h0;
	logic tick = 1'h0;
	logic rst_b_i = 1'h0;
	logic wp_i = 1'h0;
	logic lock_i = 1'h0;
	logic busy_i = 1'h0;
	logic [7:0] rd_data_i = 8'hC3;
	logic scl, m_low, sda_o, sda_oe_o, standby_o, wr_valid_o, rd_req_o, sl_wr, sl_val, prog_o, a, s, isel, frz;
	logic [1:0] fsel;
	logic [8:0] maddr;
	logic [7:0] wdata, r;
	int errors = 0, checks = 0, n_wv = 0, n_prog = 0, n_sl = 0, n_rd = 0, n_frz = 0, cyc = 0;
	wire logic sda_w;
	// Pull-up: high unless some party pulls low
	assign sda_w = !(sda_oe_o === 1'h1 && sda_o === 1'h0) && !m_low;
	always #4 clk_sys_i = ~clk_sys_i;
	initial begin
		#1;
		forever #24 tick = ~tick;
	end
	eit_master eit_master_inst (.tick_i(tick), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
	eit_target #(.TYPE_ARRAY_ID(T_ARR), .TYPE_IDENT_ID(T_ID)) eit_target_inst (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .wp_i(wp_i), .strap_select_low_i(1'h0), .strap_select_high_i(1'h1),
		.soft_write_lock_bit_i(lock_i), .ident_page_freeze_i(1'h0), .prog_busy_i(busy_i),
		.rd_data_i(rd_data_i), .standby_o(standby_o), .ident_sel_o(isel), .function_select_field_o(fsel),
		.mem_addr_o(maddr), .wr_data_o(wdata), .wr_valid_o(wr_valid_o), .rd_req_o(rd_req_o),
		.freeze_req_o(frz), .soft_lock_wr_o(sl_wr), .soft_lock_val_o(sl_val), .prog_start_o(prog_o));
	////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge clk_sys_i) begin
		n_wv += (wr_valid_o === 1'h1);
		n_prog += (prog_o === 1'h1);
		n_sl += (sl_wr === 1'h1);
		n_rd += (rd_req_o === 1'h1);
		n_frz += (frz === 1'h1);
		cyc++;
		if (cyc == 50000) begin
			errors++;
			end_sim();
		end
	end
	function automatic logic [7:0] dev(input logic [3:0] t, input logic top, input logic rw);
		return {t, 2'h2, top, rw};
	endfunction
	task automatic wr(input logic [7:0] b, input logic e);
		eit_master_inst.byte_io(b, 1'h1, r, a);
		chk(9'(a), 9'(e));
	endtask
	task automatic rd(input logic m_ack);
		eit_master_inst.byte_io(8'hFF, m_ack, r, a);
		chk(9'(r), 9'h0C3);
	endtask
	task automatic fin();
		eit_master_inst.stop();
		repeat (8) @(negedge clk_sys_i);
		chk(9'(standby_o), 9'h001);
	endtask
	initial begin
		repeat (4) @(negedge clk_sys_i);
		rst_b_i = 1'h1;
		repeat (8) @(negedge clk_sys_i);
		eit_master_inst.start();
		wr(dev(T_ARR, 1'h1, 1'h0), 1'h1);
		wr(8'h3F, 1'h1);
		chk(maddr, 9'h13F);
		wr(8'h5A, 1'h1);
		chk(maddr, 9'h130);
		chk(9'(wdata), 9'h05A);
		fin();
		chk(9'(n_prog), 9'h001);
		$display("array write done");
		for (int k = 0; k < 2; k++) begin
			@(negedge clk_sys_i);
			wp_i = (k == 0);
			lock_i = (k == 1);
			eit_master_inst.start();
			wr(dev(T_ARR, 1'h0, 1'h0), 1'h1);
			wr(8'h10, 1'h1);
			wr(8'h77, 1'h0);
			fin();
		end
		@(negedge clk_sys_i);
		wp_i = 1'h0;
		lock_i = 1'h0;
		chk(9'(n_wv + n_prog), 9'h002);
		$display("protection done");
		for (int k = 0; k < 3; k++) begin
			@(negedge clk_sys_i);
			busy_i = (k == 2);
			eit_master_inst.start();
			wr(k == 0 ? 8'h98 : k == 1 ? {T_ARR, 4'h4} : dev(T_ARR, 1'h0, 1'h0), 1'h0);
			eit_master_inst.stop();
			chk(9'(standby_o), 9'(!busy_i));
		end
		@(negedge clk_sys_i);
		busy_i = 1'h0;
		$display("refusals done");
		eit_master_inst.start();
		wr(dev(T_ARR, 1'h0, 1'h1), 1'h1);
		rd(1'h0);
		rd(1'h1);
		fin();
		chk(9'(n_rd), 9'h002);
		$display("read done");
		for (int f = 0; f < 4; f++) begin
			eit_master_inst.start();
			wr(dev(T_ID, 1'h1, 1'h0), 1'h1);
			wr({f[1:0], 6'h05}, f != 2);
			if (f != 2) begin
				chk(9'(fsel), 9'(f));
			end
			fin();
		end
		eit_master_inst.start();
		wr(dev(T_ID, 1'h1, 1'h0), 1'h1);
		wr(8'h05, 1'h1);
		chk(maddr, 9'h005);
		chk(9'(isel), 9'h001);
		eit_master_inst.start();
		wr(dev(T_ID, 1'h0, 1'h0), 1'h1);
		wr(8'h40, 1'h1);
		wr(8'h02, 1'h1);
		chk(9'(n_frz), 9'h001);
		eit_master_inst.start();
		wr(dev(T_ID, 1'h0, 1'h1), 1'h0);
		fin();
		$display("function select done");
		eit_master_inst.start();
		repeat (9) eit_master_inst.bit_io(1'h1, s);
		eit_master_inst.start();
		eit_master_inst.stop();
		eit_master_inst.start();
		repeat (3) eit_master_inst.bit_io(1'h0, s);
		eit_master_inst.start();
		wr(dev(T_ARR, 1'h0, 1'h0), 1'h1);
		chk(9'(isel), 9'h000);
		fin();
		eit_master_inst.start();
		wr(dev(T_ID, 1'h0, 1'h0), 1'h1);
		wr(8'hC0, 1'h1);
		wr(8'h01, 1'h1);
		fin();
		chk({7'h00, sl_val, 1'(n_sl)}, 9'h003);
		chk(9'(n_prog), 9'h002);
		$display("restart and lock bit done");
		end_sim();
	end
endmodule // testbench
`default_nettype wire
